//--- src/lock_delay_and_double_buffer_cfg.sv
// lock delay counter, double-buffered settings and fixed registers
// assumes calibration and phase-detector tick inputs are on clock
`timescale 1ns/1ns
`default_nettype none

module lock_delay_and_double_buffer_cfg (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [lock_cfg_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [lock_cfg_pkg::DATA_W-1:0] writedata,
   output logic [lock_cfg_pkg::DATA_W-1:0] readdata,
   output logic waitrequest,
   input wire logic osc_calibration_done,
   input wire logic phase_detector_half_tick,
   input wire logic vtune_in_range,
   output lock_cfg_pkg::lock_out_t lock_out,
   output lock_cfg_pkg::active_settings_t active_settings,
   output logic irq
);
   import lock_cfg_pkg::*;

   // ==========================================================
   // bus slave: one wait cycle, then the access completes
   logic served;
   logic wr_fire;
   logic rd_take;
   logic [INDEX_W-1:0] index;
   logic [REG_W-1:0] wmask;
   logic [REG_W-1:0] wval;

   assign index = address[ADDR_W-1:2];
   assign waitrequest = (read | write) & ~served;
   assign wr_fire = write & served;
   assign rd_take = read & ~served;
   assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
   assign wval = writedata[REG_W-1:0];

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         served <= 1'b0;
      end else begin
         served <= (read | write) & ~served;
      end
   end

   // ==========================================================
   // bank registers
   logic [REG_W-1:0] lock_detect_delay;
   logic [REG_W-1:0] fixed_cfg_3d;
   logic [REG_W-1:0] double_buffer_control;
   logic [REG_W-1:0] fixed_cfg_3f;
   logic [REG_W-1:0] fixed_cfg_40;
   logic [REG_W-1:0] fixed_cfg_41;
   logic [REG_W-1:0] fixed_cfg_42;
   logic [REG_W-1:0] fixed_cfg_43;
   logic [REG_W-1:0] main_control;
   logic soft_reset;
   logic main_write;

   function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old);
      merge = (old & ~wmask) | (wval & wmask);
   endfunction

   assign main_write = wr_fire && index == IDX_MAIN_CONTROL;
   // soft reset acts in the cycle register zero is written
   assign soft_reset = main_write && byteenable[0] && wval[BIT_SOFT_RESET];

   // soft reset bit is self-clearing, only the lock type bit is kept
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         main_control <= RST_MAIN_CONTROL;
      end else if (main_write) begin
         main_control <= merge(main_control) & 16'h0001;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lock_detect_delay <= RST_LOCK_DETECT_DELAY;
         fixed_cfg_3d <= RST_FIXED_CFG_3D;
         double_buffer_control <= RST_DOUBLE_BUFFER_CONTROL;
         fixed_cfg_3f <= RST_FIXED_CFG_3F;
         fixed_cfg_40 <= RST_FIXED_CFG_40;
         fixed_cfg_41 <= RST_FIXED_CFG_41;
         fixed_cfg_42 <= RST_FIXED_CFG_42;
         fixed_cfg_43 <= RST_FIXED_CFG_43;
      end else if (soft_reset) begin
         lock_detect_delay <= RST_LOCK_DETECT_DELAY;
         fixed_cfg_3d <= RST_FIXED_CFG_3D;
         double_buffer_control <= RST_DOUBLE_BUFFER_CONTROL;
         fixed_cfg_3f <= RST_FIXED_CFG_3F;
         fixed_cfg_40 <= RST_FIXED_CFG_40;
         fixed_cfg_41 <= RST_FIXED_CFG_41;
         fixed_cfg_42 <= RST_FIXED_CFG_42;
         fixed_cfg_43 <= RST_FIXED_CFG_43;
      end else if (wr_fire) begin
         // fixed values are stored as written; host keeps them right
         case (index)
            IDX_LOCK_DETECT_DELAY: begin
               lock_detect_delay <= merge(lock_detect_delay);
            end
            IDX_FIXED_CFG_3D: begin
               fixed_cfg_3d <= merge(fixed_cfg_3d);
            end
            IDX_DOUBLE_BUFFER_CONTROL: begin
               double_buffer_control <= merge(double_buffer_control);
            end
            IDX_FIXED_CFG_3F: begin
               fixed_cfg_3f <= merge(fixed_cfg_3f);
            end
            IDX_FIXED_CFG_40: begin
               fixed_cfg_40 <= merge(fixed_cfg_40);
            end
            IDX_FIXED_CFG_41: begin
               fixed_cfg_41 <= merge(fixed_cfg_41);
            end
            IDX_FIXED_CFG_42: begin
               fixed_cfg_42 <= merge(fixed_cfg_42);
            end
            IDX_FIXED_CFG_43: begin
               fixed_cfg_43 <= merge(fixed_cfg_43);
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // staged and active settings
   logic [NUM_SETTINGS-1:0][REG_W-1:0] stage;
   logic [NUM_SETTINGS-1:0][REG_W-1:0] active;
   logic [NUM_SETTINGS-1:0] shadow_en;
   logic [NUM_SETTINGS-1:0] stage_write;
   logic shadow_en_integer_divider;

   assign shadow_en_integer_divider =
      double_buffer_control[BIT_SHADOW_EN_INTEGER_DIVIDER];

   genvar k;
   generate
      for (k = 0; k < NUM_SETTINGS; k++) begin : g_setting
         if (k < 3) begin : g_plain
            assign shadow_en[k] =
               double_buffer_control[BIT_SHADOW_EN_MODULATOR_ORDER - k];
         end else begin : g_gated
            assign shadow_en[k] = shadow_en_integer_divider &
               double_buffer_control[BIT_SHADOW_EN_MODULATOR_ORDER - k];
         end
         assign stage_write[k] = wr_fire &&
            index == IDX_STAGE_BASE + INDEX_W'(k);

         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               stage[k] <= RST_SETTING;
            end else if (stage_write[k]) begin
               stage[k] <= merge(stage[k]);
            end
         end

         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               active[k] <= RST_SETTING;
            end else if (stage_write[k] && !shadow_en[k]) begin
               active[k] <= merge(stage[k]);
            end else if (main_write && shadow_en[k]) begin
               active[k] <= stage[k];
            end
         end
      end
   endgenerate

   assign active_settings = active_settings_t'(active);

   // ==========================================================
   // lock delay counter, counts half phase-detector ticks
   lock_state_t state;
   lock_state_t next_state;
   logic [REG_W-1:0] remain;
   logic cal_seen;
   logic cal_rise;
   logic cal_lock;
   logic lock_type_cal_only;
   logic lock_detect;
   logic lock_prev;

   assign cal_rise = osc_calibration_done & ~cal_seen;
   assign cal_lock = state == ST_LOCKED;
   assign lock_type_cal_only = ~main_control[BIT_LOCK_TYPE];

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cal_seen <= 1'b0;
      end else begin
         cal_seen <= osc_calibration_done;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (cal_rise) begin
               next_state = lock_detect_delay == 16'h0000 ? ST_LOCKED
                                                          : ST_COUNT;
            end
         end
         ST_COUNT: begin
            if (!osc_calibration_done) begin
               next_state = ST_IDLE;
            end else if (phase_detector_half_tick && remain == 16'h0001) begin
               next_state = ST_LOCKED;
            end
         end
         ST_LOCKED: begin
            if (!osc_calibration_done) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // delay value is latched at the start; later writes wait a new run
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         remain <= 16'h0000;
      end else if (state == ST_IDLE && cal_rise) begin
         remain <= lock_detect_delay;
      end else if (state == ST_COUNT && phase_detector_half_tick) begin
         remain <= remain - 16'h0001;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lock_detect <= 1'b0;
      end else begin
         lock_detect <= cal_lock & (lock_type_cal_only | vtune_in_range);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lock_prev <= 1'b0;
      end else begin
         lock_prev <= lock_detect;
      end
   end

   assign lock_out.cal_lock = cal_lock;
   assign lock_out.lock_detect = lock_detect;

   // ==========================================================
   // interrupts: sticky, write one to clear, set wins
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [2:0] irq_event;
   logic [2:0] irq_clear;

   assign irq_event[IRQ_LOCK_GAINED] = lock_detect & ~lock_prev;
   assign irq_event[IRQ_LOCK_LOST] = ~lock_detect & lock_prev;
   assign irq_event[IRQ_TRANSFER] = main_write & (|shadow_en);
   assign irq_clear = (wr_fire && index == IDX_IRQ_STATUS && byteenable[0])
                      ? wval[2:0] : 3'h0;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq_status <= RST_IRQ;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | irq_event;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq_mask <= RST_IRQ;
      end else if (wr_fire && index == IDX_IRQ_MASK && byteenable[0]) begin
         irq_mask <= wval[2:0];
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ==========================================================
   // read mux, unmapped indices read zero
   logic [REG_W-1:0] rd_value;

   always_comb begin
      rd_value = 16'h0000;
      case (index)
         IDX_MAIN_CONTROL: rd_value = main_control;
         IDX_LOCK_DETECT_DELAY: rd_value = lock_detect_delay;
         IDX_FIXED_CFG_3D: rd_value = fixed_cfg_3d;
         IDX_DOUBLE_BUFFER_CONTROL: rd_value = double_buffer_control;
         IDX_FIXED_CFG_3F: rd_value = fixed_cfg_3f;
         IDX_FIXED_CFG_40: rd_value = fixed_cfg_40;
         IDX_FIXED_CFG_41: rd_value = fixed_cfg_41;
         IDX_FIXED_CFG_42: rd_value = fixed_cfg_42;
         IDX_FIXED_CFG_43: rd_value = fixed_cfg_43;
         IDX_IRQ_STATUS: rd_value = {13'h0000, irq_status};
         IDX_IRQ_MASK: rd_value = {13'h0000, irq_mask};
         IDX_LOCK_STATE: rd_value = {11'h000, state, lock_detect, cal_lock};
         default: begin
            if (index >= IDX_STAGE_BASE &&
                index < IDX_STAGE_BASE + INDEX_W'(NUM_SETTINGS)) begin
               rd_value = stage[3'(index - IDX_STAGE_BASE)];
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         readdata <= 32'h0000_0000;
      end else if (rd_take) begin
         readdata <= {16'h0000, rd_value};
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   // only the last pending half tick may end the wait
   property p_lock_waits;
      state == ST_COUNT &&
         !(phase_detector_half_tick && remain == 16'h0001) |=> !cal_lock;
   endproperty
   a_lock_waits: assert property (p_lock_waits)
      else $error("lock raised before delay expired");

   property p_order_direct;
      stage_write[0] && !double_buffer_control[15] |=> active[0] == stage[0];
   endproperty
   a_order_direct: assert property (p_order_direct)
      else $error("modulator order not applied directly");

   property p_frac_held;
      stage_write[1] && double_buffer_control[14] |=> $stable(active[1]);
   endproperty
   a_frac_held: assert property (p_frac_held)
      else $error("staged numerator reached active early");

   property p_int_direct;
      stage_write[2] && !double_buffer_control[13] |=> active[2] == stage[2];
   endproperty
   a_int_direct: assert property (p_int_direct)
      else $error("integer divider not applied directly");

   property p_refdiv_ungated;
      stage_write[3] && double_buffer_control[12] &&
         !double_buffer_control[13] |=> active[3] == stage[3];
   endproperty
   a_refdiv_ungated: assert property (p_refdiv_ungated)
      else $error("ref divider staged without integer bit");

   property p_mult_held;
      stage_write[4] && double_buffer_control[11] &&
         double_buffer_control[13] |=> $stable(active[4]);
   endproperty
   a_mult_held: assert property (p_mult_held)
      else $error("staged multiplier reached active early");

   property p_doubler_ungated;
      stage_write[5] && double_buffer_control[10] &&
         !double_buffer_control[13] |=> active[5] == stage[5];
   endproperty
   a_doubler_ungated: assert property (p_doubler_ungated)
      else $error("doubler staged without integer bit");

   property p_soft_reset;
      soft_reset |=> fixed_cfg_40 == RST_FIXED_CFG_40 &&
         fixed_cfg_42 == RST_FIXED_CFG_42 && fixed_cfg_3d == RST_FIXED_CFG_3D
         && double_buffer_control == RST_DOUBLE_BUFFER_CONTROL;
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("soft reset left a fixed register changed");

   property p_cal_only;
      lock_detect && !main_control[0] |-> $past(cal_lock);
   endproperty
   a_cal_only: assert property (p_cal_only)
      else $error("lock output high without calibration lock");

   property p_transfer;
      main_write && shadow_en[1] |=> active[1] == $past(stage[1]);
   endproperty
   a_transfer: assert property (p_transfer)
      else $error("staged numerator not transferred");

endmodule // lock_delay_and_double_buffer_cfg

`default_nettype wire

//--- src/lock_cfg_pkg.sv
// shared constants and types of the lock delay and double-buffer bank
// assumes a 16-bit register bank behind a 32-bit Avalon-MM slave
package lock_cfg_pkg;

   // ==========================================================
   // bus geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int INDEX_W = 8;
   localparam int NUM_SETTINGS = 6;

   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_MAIN_CONTROL = 8'h00;
   localparam logic [7:0] IDX_LOCK_DETECT_DELAY = 8'h3C;
   localparam logic [7:0] IDX_FIXED_CFG_3D = 8'h3D;
   localparam logic [7:0] IDX_DOUBLE_BUFFER_CONTROL = 8'h3E;
   localparam logic [7:0] IDX_FIXED_CFG_3F = 8'h3F;
   localparam logic [7:0] IDX_FIXED_CFG_40 = 8'h40;
   localparam logic [7:0] IDX_FIXED_CFG_41 = 8'h41;
   localparam logic [7:0] IDX_FIXED_CFG_42 = 8'h42;
   localparam logic [7:0] IDX_FIXED_CFG_43 = 8'h43;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h50;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h51;
   localparam logic [7:0] IDX_LOCK_STATE = 8'h52;
   // staged settings occupy this index and the five after it
   localparam logic [7:0] IDX_STAGE_BASE = 8'h60;

   // ==========================================================
   // reset values
   localparam logic [15:0] RST_LOCK_DETECT_DELAY = 16'h03E8;
   localparam logic [15:0] RST_FIXED_CFG_3D = 16'h00A8;
   localparam logic [15:0] RST_DOUBLE_BUFFER_CONTROL = 16'h00AF;
   localparam logic [15:0] RST_FIXED_CFG_3F = 16'h0000;
   localparam logic [15:0] RST_FIXED_CFG_40 = 16'h1388;
   localparam logic [15:0] RST_FIXED_CFG_41 = 16'h0000;
   localparam logic [15:0] RST_FIXED_CFG_42 = 16'h01F4;
   localparam logic [15:0] RST_FIXED_CFG_43 = 16'h0000;
   localparam logic [15:0] RST_MAIN_CONTROL = 16'h0000;
   localparam logic [15:0] RST_SETTING = 16'h0000;
   localparam logic [2:0] RST_IRQ = 3'h0;

   // ==========================================================
   // field positions
   localparam int BIT_SOFT_RESET = 1;
   localparam int BIT_LOCK_TYPE = 0;
   localparam int BIT_SHADOW_EN_MODULATOR_ORDER = 15;
   localparam int BIT_SHADOW_EN_INTEGER_DIVIDER = 13;
   localparam int BIT_SHADOW_EN_REF_DOUBLER = 10;
   localparam int IRQ_LOCK_GAINED = 0;
   localparam int IRQ_LOCK_LOST = 1;
   localparam int IRQ_TRANSFER = 2;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_COUNT = 3'b010,
      ST_LOCKED = 3'b100
   } lock_state_t;

   typedef struct packed {
      logic [15:0] ref_doubler;
      logic [15:0] ref_multiplier;
      logic [15:0] ref_dividers;
      logic [15:0] integer_divider;
      logic [15:0] frac_numerator;
      logic [15:0] modulator_order;
   } active_settings_t;

   typedef struct packed {
      logic cal_lock;
      logic lock_detect;
   } lock_out_t;

endpackage

//--- bench/avalon_host_model.sv
// host side model: avalon-mm master that programs the register bank
// assumes tasks are entered just after a rising edge of clock
`timescale 1ns/1ns
`default_nettype none
module avalon_host_model (
   input wire logic clock,
   input wire logic waitrequest,
   input wire logic [lock_cfg_pkg::DATA_W-1:0] readdata,
   output logic [lock_cfg_pkg::ADDR_W-1:0] address,
   output logic read,
   output logic write,
   output logic [3:0] byteenable,
   output logic [lock_cfg_pkg::DATA_W-1:0] writedata
);
   import lock_cfg_pkg::*;
   int stall_count = 0;

   initial begin
      address = '0;
      read = 1'b0;
      write = 1'b0;
      byteenable = 4'h0;
      writedata = '0;
   end

   // =====================================
   // bus cycle
   // leading edge wait keeps a released strobe from being raised in the
   // same time step
   task automatic access(input logic is_wr, input logic [7:0] idx,
      input logic [15:0] data, output logic [31:0] got);
      int n;
      @(posedge clock);
      address <= {idx, 2'b00};
      byteenable <= 4'h3;
      writedata <= {16'h0000, data};
      read <= ~is_wr;
      write <= is_wr;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (waitrequest !== 1'b0) stall_count++;
      got = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [15:0] data);
      logic [31:0] d;
      access(1'b1, idx, data, d);
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] got);
      access(1'b0, idx, 16'h0000, got);
   endtask

   // =====================================
   // prescribed values
   task automatic prog_fixed(input logic [5:0] en);
      wr(IDX_DOUBLE_BUFFER_CONTROL, {en, 10'h0AF});
      wr(IDX_FIXED_CFG_3D, 16'h00A8);
      wr(IDX_FIXED_CFG_3F, 16'h0000);
      wr(IDX_FIXED_CFG_41, 16'h0000);
      wr(IDX_FIXED_CFG_40, 16'h1388);
      wr(IDX_FIXED_CFG_42, 16'h01F4);
   endtask

   task automatic soft_reset();
      wr(IDX_MAIN_CONTROL, 16'h0002);
   endtask
endmodule // avalon_host_model
`default_nettype wire

//--- bench/lock_delay_and_double_buffer_cfg_tb_top.sv
// self-checking bench for the lock delay and double-buffer bank
// assumes avalon_host_model drives the register bus
`timescale 1ns/1ns
`default_nettype none
module lock_delay_and_double_buffer_cfg_tb_top;
   import lock_cfg_pkg::*;
   localparam logic [15:0] RST_TAB [8] = '{RST_LOCK_DETECT_DELAY,
      RST_FIXED_CFG_3D, RST_DOUBLE_BUFFER_CONTROL, RST_FIXED_CFG_3F,
      RST_FIXED_CFG_40, RST_FIXED_CFG_41, RST_FIXED_CFG_42, RST_FIXED_CFG_43};
   localparam logic [5:0] PAT [5] = '{6'h00, 6'h3F, 6'h07, 6'h0F, 6'h38};
   logic clock, rstn, read, write, waitrequest, irq;
   logic osc_calibration_done, phase_detector_half_tick, vtune_in_range;
   logic [ADDR_W-1:0] address;
   logic [3:0] byteenable;
   logic [DATA_W-1:0] writedata, readdata, got;
   lock_out_t lock_out;
   active_settings_t active_settings;
   logic [15:0] exp_stage [6];
   logic [15:0] exp_act [6];
   int err_total = 0;
   int total_checks = 0;

   lock_delay_and_double_buffer_cfg i_lock_delay_and_double_buffer_cfg (
      .clock(clock), .rstn(rstn), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest),
      .osc_calibration_done(osc_calibration_done),
      .phase_detector_half_tick(phase_detector_half_tick),
      .vtune_in_range(vtune_in_range), .lock_out(lock_out),
      .active_settings(active_settings), .irq(irq));

   avalon_host_model i_avalon_host_model (
      .clock(clock), .waitrequest(waitrequest), .readdata(readdata),
      .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // =====================================
   // helpers
   task automatic wrap_up();
      if (err_total == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp,
      input logic [31:0] seen);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic chk_reg(input logic [7:0] idx, input logic [15:0] exp);
      i_avalon_host_model.rd(idx, got);
      chk($sformatf("reg %h", idx), {16'h0000, exp}, got);
   endtask

   // active copies land on the completing edge itself
   task automatic chk_active();
      repeat (2) @(posedge clock);
      for (int k = 0; k < 6; k++)
         chk($sformatf("active %0d", k), {16'h0000, exp_act[k]},
            {16'h0000, active_settings[16*k +: 16]});
   endtask

   task automatic half_tick();
      repeat (2) @(posedge clock);
      phase_detector_half_tick <= 1'b1;
      @(posedge clock);
      phase_detector_half_tick <= 1'b0;
   endtask

   task automatic scramble();
      for (int k = 0; k < 7; k++)
         i_avalon_host_model.wr(8'h3C + 8'(k), 16'h5A50 + 16'(k));
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      wrap_up();
   end

   // =====================================
   // main sequence
   initial begin
      logic [15:0] val;
      logic eff;
      int n;
      rstn = 1'b0;
      osc_calibration_done = 1'b0;
      phase_detector_half_tick = 1'b0;
      vtune_in_range = 1'b0;
      for (int k = 0; k < 6; k++) exp_stage[k] = RST_SETTING;
      exp_act = exp_stage;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      for (int k = 0; k < 8; k++) chk_reg(8'h3C + 8'(k), RST_TAB[k]);
      i_avalon_host_model.wr(8'h70, 16'hFFFF);
      chk_reg(8'h70, 16'h0000);
      scramble();
      i_avalon_host_model.prog_fixed(6'h00);
      for (int k = 1; k < 7; k++) chk_reg(8'h3C + 8'(k), RST_TAB[k]);
      scramble();
      i_avalon_host_model.soft_reset();
      for (int k = 0; k < 8; k++) chk_reg(8'h3C + 8'(k), RST_TAB[k]);
      chk_reg(IDX_MAIN_CONTROL, 16'h0000);
      // settings with each enable pattern, then a transfer
      for (int p = 0; p < 5; p++) begin
         i_avalon_host_model.wr(IDX_DOUBLE_BUFFER_CONTROL, {PAT[p], 10'h0AF});
         for (int k = 0; k < 6; k++) begin
            val = 16'((p << 8) + k + 1);
            // reference path bits count only with the integer bit set
            eff = PAT[p][5-k] & (k < 3 || PAT[p][3]);
            i_avalon_host_model.wr(IDX_STAGE_BASE + 8'(k), val);
            exp_stage[k] = val;
            if (!eff) exp_act[k] = val;
         end
         chk_active();
         i_avalon_host_model.wr(IDX_MAIN_CONTROL, 16'h0000);
         exp_act = exp_stage;
         chk_active();
      end
      // lock delay of three half ticks
      i_avalon_host_model.wr(IDX_LOCK_DETECT_DELAY, 16'h0003);
      i_avalon_host_model.wr(IDX_IRQ_MASK, 16'h0001);
      i_avalon_host_model.wr(IDX_IRQ_STATUS, 16'h0007);
      @(posedge clock);
      chk("irq idle", 1'b0, irq);
      osc_calibration_done <= 1'b1;
      vtune_in_range <= 1'b1;
      half_tick();
      half_tick();
      repeat (3) @(posedge clock);
      chk("early lock", 1'b0, lock_out.cal_lock);
      half_tick();
      n = 0;
      while (lock_out.cal_lock !== 1'b1 && n < 3) begin
         @(posedge clock);
         n++;
      end
      chk("lock after delay", 1'b1, lock_out.cal_lock);
      repeat (3) @(posedge clock);
      chk("lock detect", 1'b1, lock_out.lock_detect);
      chk("irq lock", 1'b1, irq);
      chk_reg(IDX_LOCK_STATE, 16'h0013);
      i_avalon_host_model.wr(IDX_IRQ_STATUS, 16'h0001);
      @(posedge clock);
      chk("irq cleared", 1'b0, irq);
      osc_calibration_done <= 1'b0;
      repeat (3) @(posedge clock);
      chk("lock dropped", 1'b0, lock_out.cal_lock);
      chk("irq masked", 1'b0, irq);
      // tuning-voltage type: zero delay, lock waits for vtune
      i_avalon_host_model.wr(IDX_LOCK_DETECT_DELAY, 16'h0000);
      i_avalon_host_model.wr(IDX_MAIN_CONTROL, 16'h0001);
      vtune_in_range <= 1'b0;
      osc_calibration_done <= 1'b1;
      repeat (4) @(posedge clock);
      chk("zero delay lock", 1'b1, lock_out.cal_lock);
      chk("vtune gate", 1'b0, lock_out.lock_detect);
      vtune_in_range <= 1'b1;
      repeat (3) @(posedge clock);
      chk("vtune lock", 1'b1, lock_out.lock_detect);
      chk("bus stalls", 32'h0, i_avalon_host_model.stall_count);
      wrap_up();
   end
endmodule // lock_delay_and_double_buffer_cfg_tb_top
`default_nettype wire
